/* adcseq_map.svh */
// register offsets, field positions and timing counts of the conversion sequencer
`ifndef ADCSEQ_MAP_SVH
`define ADCSEQ_MAP_SVH
`define ADCSEQ_OFS_CS        5'h00
`define ADCSEQ_OFS_TRC       5'h04
`define ADCSEQ_OFS_RES_A     5'h08
`define ADCSEQ_OFS_RES_B     5'h0C
`define ADCSEQ_OFS_RES_C     5'h10
`define ADCSEQ_OFS_RES_D     5'h14
`define ADCSEQ_CS_FLAG       7
`define ADCSEQ_CS_IE         6
`define ADCSEQ_CS_START      5
`define ADCSEQ_CS_SCAN       4
`define ADCSEQ_CS_CKS        3
`define ADCSEQ_CS_RESET      8'h00
`define ADCSEQ_TRC_RESET     2'h0
`define ADCSEQ_TRC_RSVD      6'h3F
`define ADCSEQ_TRG_TIMER     2'h2
`define ADCSEQ_TRG_PIN       2'h3
`define ADCSEQ_RES_LOW_W     6
// a state is one clock period at 20 MHz
`define ADCSEQ_CLK_PER_ST    1
`define ADCSEQ_CONV0_MAX_ST  266
`define ADCSEQ_CONV1_MAX_ST  134
`define ADCSEQ_DLY0_ST       10
`define ADCSEQ_DLY1_ST       6
`define ADCSEQ_SPL0_ST       63
`define ADCSEQ_SPL1_ST       31
`define ADCSEQ_STEP0_ST      19
`define ADCSEQ_STEP1_ST      9
`define ADCSEQ_DLY0_CYC      (`ADCSEQ_DLY0_ST * `ADCSEQ_CLK_PER_ST)
`define ADCSEQ_DLY1_CYC      (`ADCSEQ_DLY1_ST * `ADCSEQ_CLK_PER_ST)
`define ADCSEQ_SPL0_CYC      (`ADCSEQ_SPL0_ST * `ADCSEQ_CLK_PER_ST)
`define ADCSEQ_SPL1_CYC      (`ADCSEQ_SPL1_ST * `ADCSEQ_CLK_PER_ST)
`define ADCSEQ_STEP0_CYC     (`ADCSEQ_STEP0_ST * `ADCSEQ_CLK_PER_ST)
`define ADCSEQ_STEP1_CYC     (`ADCSEQ_STEP1_ST * `ADCSEQ_CLK_PER_ST)
`define ADCSEQ_CNV0_CYC      ((`ADCSEQ_CONV0_MAX_ST - `ADCSEQ_DLY0_ST - `ADCSEQ_SPL0_ST) * `ADCSEQ_CLK_PER_ST)
`define ADCSEQ_CNV1_CYC      ((`ADCSEQ_CONV1_MAX_ST - `ADCSEQ_DLY1_ST - `ADCSEQ_SPL1_ST) * `ADCSEQ_CLK_PER_ST)
`endif

/* adcseq_pkg.sv */
// types of the conversion sequencer
package adcseq_pkg;
   typedef enum logic [1:0] {
      ADCSEQ_IDLE   = 2'b00,
      ADCSEQ_DELAY  = 2'b01,
      ADCSEQ_SAMPLE = 2'b10,
      ADCSEQ_CONV   = 2'b11
   } adcseq_state_type;
endpackage : adcseq_pkg

/* adcseq_sar.sv */
// successive-approximation register, one bit decided per step pulse
`timescale 1ns/100ps
module adcseq_sar #(
   parameter int RES_W = 10
) (
   input  wire logic             core_clk_i,
   input  wire logic             rstn_i,
   input  wire logic             start_i,
   input  wire logic             step_i,
   input  wire logic             cmp_hi_i,
   output logic      [RES_W-1:0] trial_o,
   output logic      [RES_W-1:0] result_o
);
   logic [RES_W-1:0] mask;
   logic [RES_W-1:0] next_mask;
   logic [RES_W-1:0] next_trial;
   logic [RES_W-1:0] next_result;
   logic [RES_W-1:0] kept;

   always_comb begin
      next_mask   = mask;
      next_trial  = trial_o;
      next_result = result_o;
      // keep the trial bit while the input is at or above the trial level
      kept = cmp_hi_i ? trial_o : (trial_o & ~mask);
      if (start_i) begin
         next_mask  = {1'h1, {(RES_W-1){1'h0}}};
         next_trial = {1'h1, {(RES_W-1){1'h0}}};
      end else if (step_i && mask != '0) begin
         next_mask  = mask >> 1;
         next_trial = kept | (mask >> 1);
         if (mask[0]) begin
            next_result = kept;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mask     <= '0;
         trial_o  <= '0;
         result_o <= '0;
      end else begin
         mask     <= next_mask;
         trial_o  <= next_trial;
         result_o <= next_result;
      end
   end
endmodule : adcseq_sar

/* adcseq_top.sv */
// register front end and conversion sequencer of the 10-bit converter
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
`include "adcseq_map.svh"
// Behaviour
// - writing start 1 begins conversion; writing 0 stops it
// - single mode clears start by itself when its conversion ends
// - scan repeats until start cleared by software, reset, standby or stop
// - mode bit 4: 0 single, 1 scan
// - speed bit 3: at most 266 states when 0, 134 when 1
// - channel code picks input or scan group; codes 110 and 111 prohibited
// - one write may set start together with new mode and channel
// - done flag accepts only written 0; written 1 leaves it
// - trigger field 00/01 no hardware start, 10 timer, 11 pin
// - trigger register bits 5 to 0 read 1 and ignore writes
// - 10-bit successive approximation, single and scan modes only
// - single conversion starts when start becomes 1 by any source
// - finished result goes to the input's result register
// - single completion sets done flag; interrupt if enabled
// - start reads 1 throughout single conversion, then converter idles
// - result word holds value in bits 15 to 6, low 6 read 0
// - upper byte read copies lower byte to holding register
// - done flag clears only by 0 written after reading it as 1
// - pin trigger: falling edge on pin sets start bit
module adcseq_top #(
   parameter int RES_W = 10
) (
   input  wire logic             core_clk_i,
   input  wire logic             rstn_i,
   input  wire logic [4:0]       avs_address_i,
   input  wire logic             avs_read_i,
   input  wire logic             avs_write_i,
   input  wire logic [31:0]      avs_writedata_i,
   input  wire logic [3:0]       avs_byteenable_i,
   output logic      [31:0]      avs_readdata_o,
   output logic                  avs_waitrequest_o,
   input  wire logic             timer_module_trig_i,
   input  wire logic             external_trigger_pin_n_i,
   input  wire logic             standby_i,
   input  wire logic             module_stop_i,
   input  wire logic             cmp_hi_i,
   output logic      [RES_W-1:0] dac_code_o,
   output logic      [2:0]       input_select_o,
   output logic                  sample_o,
   output logic                  conversion_done_interrupt_o
);
   localparam logic [8:0] DLY0 = 9'(`ADCSEQ_DLY0_CYC);
   localparam logic [8:0] DLY1 = 9'(`ADCSEQ_DLY1_CYC);
   localparam logic [8:0] SPL0 = 9'(`ADCSEQ_SPL0_CYC);
   localparam logic [8:0] SPL1 = 9'(`ADCSEQ_SPL1_CYC);
   localparam logic [8:0] CNV0 = 9'(`ADCSEQ_CNV0_CYC);
   localparam logic [8:0] CNV1 = 9'(`ADCSEQ_CNV1_CYC);
   localparam logic [4:0] STP0 = 5'(`ADCSEQ_STEP0_CYC);
   localparam logic [4:0] STP1 = 5'(`ADCSEQ_STEP1_CYC);

   // control and status fields
   logic                     done_flag;
   logic                     irq_en;
   logic                     start;
   logic                     scan;
   logic                     conversion_speed_select;
   logic [2:0]               chan;
   logic [1:0]               trg;
   logic                     armed;
   logic [RES_W-1:0]         res [4];
   logic                     next_done_flag;
   logic                     next_irq_en;
   logic                     next_start;
   logic                     next_scan;
   logic                     next_cks;
   logic [2:0]               next_chan;
   logic [1:0]               next_trg;
   logic                     next_armed;
   logic [RES_W-1:0]         next_res [4];
   logic                     next_irq;

   // sequencer
   adcseq_pkg::adcseq_state_type state;
   adcseq_pkg::adcseq_state_type next_state;
   logic [8:0]               cnt;
   logic [8:0]               next_cnt;
   logic [4:0]               step_cnt;
   logic [4:0]               next_step_cnt;
   logic [2:0]               next_input_sel;
   logic                     first;
   logic                     next_first;
   logic                     next_sample;
   logic                     sar_start;
   logic                     sar_step;
   logic [RES_W-1:0]         sar_result;

   // bus
   logic                     ack;
   logic                     next_ack;
   logic [31:0]              next_rdata;
   logic [7:0]               temp;
   logic [7:0]               next_temp;

   // pin synchronisers
   logic                     cmp_s1;
   logic                     cmp_s2;
   logic                     trg_s1;
   logic                     trg_s2;
   logic                     trg_s3;

   logic [2:0]               widx;
   logic [1:0]               res_idx;
   logic                     req;
   logic                     take;
   logic                     hit_cs;
   logic                     hit_trc;
   logic                     hit_res;
   logic                     wr_cs;
   logic                     wr_trc;
   logic                     ext_fall;
   logic                     hw_trig;
   logic                     stop_req;
   logic                     prohibited;
   logic                     go;
   logic                     conv_end;
   logic                     group_last;
   logic [2:0]               first_ch;
   logic [2:0]               last_ch;
   logic [8:0]               dly_len;
   logic [8:0]               spl_len;
   logic [8:0]               cnv_len;
   logic [4:0]               stp_len;
   logic [7:0]               cs_val;

   assign widx       = avs_address_i[4:2];
   assign res_idx    = 2'(widx - 3'h2);
   assign req        = avs_read_i | avs_write_i;
   assign take       = req & ack;
   assign hit_cs     = avs_address_i == `ADCSEQ_OFS_CS;
   assign hit_trc    = avs_address_i == `ADCSEQ_OFS_TRC;
   assign hit_res    = avs_address_i >= `ADCSEQ_OFS_RES_A && avs_address_i <= `ADCSEQ_OFS_RES_D
                       && avs_address_i[1:0] == 2'h0;
   assign wr_cs      = take & avs_write_i & hit_cs & avs_byteenable_i[0];
   assign wr_trc     = take & avs_write_i & hit_trc & avs_byteenable_i[0];
   assign avs_waitrequest_o = req & ~ack;
   assign cs_val     = {done_flag, irq_en, start, scan, conversion_speed_select, chan};

   assign ext_fall   = trg_s3 & ~trg_s2;
   assign hw_trig    = (trg == `ADCSEQ_TRG_TIMER && timer_module_trig_i)
                       || (trg == `ADCSEQ_TRG_PIN && ext_fall);
   assign stop_req   = standby_i | module_stop_i;
   assign prohibited = chan[2:1] == 2'h3;
   assign go         = state == adcseq_pkg::ADCSEQ_IDLE && start && !prohibited;
   assign dly_len    = conversion_speed_select ? DLY1 : DLY0;
   assign spl_len    = conversion_speed_select ? SPL1 : SPL0;
   assign cnv_len    = conversion_speed_select ? CNV1 : CNV0;
   assign stp_len    = conversion_speed_select ? STP1 : STP0;
   assign conv_end   = state == adcseq_pkg::ADCSEQ_CONV && start && cnt == cnv_len - 9'h001;
   assign sar_step   = state == adcseq_pkg::ADCSEQ_CONV && step_cnt == stp_len - 5'h01;
   assign sar_start  = state == adcseq_pkg::ADCSEQ_SAMPLE && cnt == spl_len - 9'h001;
   // scan groups: 0xx walks from input 0, 1xx from input 4
   assign first_ch   = scan ? {chan[2], 2'h0} : chan;
   assign last_ch    = chan[2] ? {1'h1, 1'h0, chan[0]} : chan;
   assign group_last = input_select_o == last_ch;

   adcseq_sar #(
      .RES_W(RES_W)
   ) u_sar (
      .core_clk_i(core_clk_i),
      .rstn_i    (rstn_i),
      .start_i   (sar_start),
      .step_i    (sar_step),
      .cmp_hi_i  (cmp_s2),
      .trial_o   (dac_code_o),
      .result_o  (sar_result)
   );

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cmp_s1 <= 1'h0;
         cmp_s2 <= 1'h0;
         trg_s1 <= 1'h1;
         trg_s2 <= 1'h1;
         trg_s3 <= 1'h1;
      end else begin
         cmp_s1 <= cmp_hi_i;
         cmp_s2 <= cmp_s1;
         trg_s1 <= external_trigger_pin_n_i;
         trg_s2 <= trg_s1;
         trg_s3 <= trg_s2;
      end
   end

   // bus slave: one wait cycle, read data registered
   always_comb begin
      next_ack   = req & ~ack;
      next_rdata = 32'h0000_0000;
      next_temp  = temp;
      if (req && !ack && avs_read_i) begin
         if (hit_cs) begin
            next_rdata = {24'h00_0000, cs_val};
         end else if (hit_trc) begin
            next_rdata = {24'h00_0000, trg, `ADCSEQ_TRC_RSVD};
         end else if (hit_res && avs_byteenable_i[1:0] == 2'h1) begin
            next_rdata = {24'h00_0000, temp};
         end else if (hit_res) begin
            next_rdata = 32'({res[res_idx], 6'h00});
         end
      end
      if (take && avs_read_i && hit_res && avs_byteenable_i[1]) begin
         next_temp = {res[res_idx][1:0], 6'h00};
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack            <= 1'h0;
         avs_readdata_o <= 32'h0000_0000;
         temp           <= 8'h00;
      end else begin
         ack            <= next_ack;
         avs_readdata_o <= next_rdata;
         temp           <= next_temp;
      end
   end

   // registers and sequencer
   always_comb begin
      next_done_flag = done_flag;
      next_irq_en    = irq_en;
      next_start     = start;
      next_scan      = scan;
      next_cks       = conversion_speed_select;
      next_chan      = chan;
      next_trg       = trg;
      next_armed     = armed;
      next_res       = res;
      next_state     = state;
      next_cnt       = cnt + 9'h001;
      next_step_cnt  = 5'h00;
      next_input_sel = input_select_o;
      next_first     = first;
      next_sample    = 1'h0;
      if (take && avs_read_i && hit_cs && avs_readdata_o[`ADCSEQ_CS_FLAG]) begin
         next_armed = 1'h1;
      end
      if (wr_cs) begin
         if (!avs_writedata_i[`ADCSEQ_CS_FLAG] && armed) begin
            next_done_flag = 1'h0;
            next_armed     = 1'h0;
         end
         next_irq_en = avs_writedata_i[`ADCSEQ_CS_IE];
         next_scan   = avs_writedata_i[`ADCSEQ_CS_SCAN];
         next_cks    = avs_writedata_i[`ADCSEQ_CS_CKS];
         next_chan   = avs_writedata_i[2:0];
      end
      if (wr_trc) begin
         next_trg = avs_writedata_i[7:6];
      end
      case (state)
         adcseq_pkg::ADCSEQ_IDLE: begin
            next_cnt = 9'h000;
            if (go) begin
               next_state     = adcseq_pkg::ADCSEQ_DELAY;
               next_input_sel = first_ch;
               next_first     = 1'h1;
               next_cnt       = 9'h001;
            end else if (start) begin
               next_start = 1'h0;
            end
         end
         adcseq_pkg::ADCSEQ_DELAY: begin
            if (cnt >= dly_len - 9'h001) begin
               next_state  = adcseq_pkg::ADCSEQ_SAMPLE;
               next_cnt    = 9'h000;
               next_sample = 1'h1;
            end
         end
         adcseq_pkg::ADCSEQ_SAMPLE: begin
            next_sample = 1'h1;
            if (sar_start) begin
               next_state  = adcseq_pkg::ADCSEQ_CONV;
               next_cnt    = 9'h000;
               next_sample = 1'h0;
            end
         end
         adcseq_pkg::ADCSEQ_CONV: begin
            next_step_cnt = sar_step ? 5'h00 : step_cnt + 5'h01;
            if (conv_end) begin
               next_res[input_select_o[1:0]] = sar_result;
               next_cnt                      = 9'h000;
               next_first                    = 1'h0;
               if (!scan) begin
                  next_state     = adcseq_pkg::ADCSEQ_IDLE;
                  next_start     = 1'h0;
                  next_done_flag = 1'h1;
               end else begin
                  next_state  = adcseq_pkg::ADCSEQ_SAMPLE;
                  next_sample = 1'h1;
                  if (group_last) begin
                     next_done_flag = 1'h1;
                     next_input_sel = first_ch;
                  end else begin
                     next_input_sel = input_select_o + 3'h1;
                  end
               end
            end
         end
         default: begin
            next_state = adcseq_pkg::ADCSEQ_IDLE;
         end
      endcase
      // a cleared start aborts whatever phase is running
      if (state != adcseq_pkg::ADCSEQ_IDLE && !start) begin
         next_state  = adcseq_pkg::ADCSEQ_IDLE;
         next_sample = 1'h0;
      end
      if (wr_cs) begin
         next_start = avs_writedata_i[`ADCSEQ_CS_START];
      end
      if (hw_trig) begin
         next_start = 1'h1;
      end
      if (stop_req) begin
         next_start = 1'h0;
      end
      next_irq = next_done_flag & next_irq_en;
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         done_flag      <= 1'h0;
         irq_en         <= 1'h0;
         start          <= 1'h0;
         scan           <= 1'h0;
         conversion_speed_select            <= 1'h0;
         chan           <= 3'h0;
         trg            <= `ADCSEQ_TRC_RESET;
         armed          <= 1'h0;
         res            <= '{default: '0};
         state          <= adcseq_pkg::ADCSEQ_IDLE;
         cnt            <= 9'h000;
         step_cnt       <= 5'h00;
         input_select_o <= 3'h0;
         first          <= 1'h0;
         sample_o       <= 1'h0;
         conversion_done_interrupt_o <= 1'h0;
      end else begin
         done_flag      <= next_done_flag;
         irq_en         <= next_irq_en;
         start          <= next_start;
         scan           <= next_scan;
         conversion_speed_select            <= next_cks;
         chan           <= next_chan;
         trg            <= next_trg;
         armed          <= next_armed;
         res            <= next_res;
         state          <= next_state;
         cnt            <= next_cnt;
         step_cnt       <= next_step_cnt;
         input_select_o <= next_input_sel;
         first          <= next_first;
         sample_o       <= next_sample;
         conversion_done_interrupt_o <= next_irq;
      end
   end

   // cycles since the start bit was taken or the previous conversion ended, used only by checks
   logic [8:0] tot;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tot <= 9'h000;
      end else begin
         tot <= (conv_end || state == adcseq_pkg::ADCSEQ_IDLE) ? 9'h000 : tot + 9'h001;
      end
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);

   property p_stop;
      wr_cs && !avs_writedata_i[`ADCSEQ_CS_START] && !hw_trig |=> !start ##1 state == adcseq_pkg::ADCSEQ_IDLE;
   endproperty
   a_stop: assert property (p_stop) else $error("start not stopped");

   property p_single_clr;
      conv_end && !scan && !wr_cs && !hw_trig |=> !start && done_flag;
   endproperty
   a_single_clr: assert property (p_single_clr) else $error("single end wrong");

   property p_scan_keep;
      conv_end && scan && !wr_cs && !stop_req |=> start && state == adcseq_pkg::ADCSEQ_SAMPLE;
   endproperty
   a_scan_keep: assert property (p_scan_keep) else $error("scan did not continue");

   property p_len;
      conv_end |-> tot == (first ? (conversion_speed_select ? 9'h084 : 9'h108) : (conversion_speed_select ? 9'h07F : 9'h0FF));
   endproperty
   a_len: assert property (p_len) else $error("conversion length wrong");

   property p_flag_w1;
      wr_cs && avs_writedata_i[`ADCSEQ_CS_FLAG] && done_flag |=> done_flag;
   endproperty
   a_flag_w1: assert property (p_flag_w1) else $error("flag cleared by 1");

   property p_trg_off;
      state == adcseq_pkg::ADCSEQ_IDLE && !start && !trg[1] && !wr_cs |=> !start;
   endproperty
   a_trg_off: assert property (p_trg_off) else $error("start without trigger");

   property p_trc_ones;
      ack && avs_read_i && hit_trc |-> avs_readdata_o[5:0] == `ADCSEQ_TRC_RSVD;
   endproperty
   a_trc_ones: assert property (p_trc_ones) else $error("reserved bits not one");

   property p_res_low;
      ack && avs_read_i && hit_res && avs_byteenable_i[1:0] == 2'h3 |-> avs_readdata_o[5:0] == 6'h00;
   endproperty
   a_res_low: assert property (p_res_low) else $error("result low bits set");

   property p_irq;
      conv_end && !scan && irq_en && !wr_cs |=> conversion_done_interrupt_o;
   endproperty
   a_irq: assert property (p_irq) else $error("done interrupt missing");

   property p_ext;
      trg == `ADCSEQ_TRG_PIN && ext_fall && !stop_req |=> start;
   endproperty
   a_ext: assert property (p_ext) else $error("pin edge did not start");
endmodule : adcseq_top

/* adcseq_analog_model.sv */
// analog inputs and comparator facing the conversion sequencer
`timescale 1ns/100ps
module adcseq_analog_model (
   input  wire logic [2:0] input_select_i,
   input  wire logic [9:0] dac_code_i,
   output logic            cmp_hi_o
);
   logic [9:0] level;
   // each input holds its own fixed level
   assign level    = 10'h155 + 10'h044 * input_select_i;
   assign cmp_hi_o = (level >= dac_code_i);
endmodule : adcseq_analog_model

/* testbench.sv */
// self-checking bench of the conversion sequencer
`timescale 1ns/100ps
module testbench;
   logic        clk;
   logic        rstn;
   logic        rd;
   logic        wr;
   logic        wreq;
   logic        tmr;
   logic        pin_n;
   logic        stby;
   logic        mstop;
   logic        cmp;
   logic        smp;
   logic        irq;
   logic [4:0]  adr;
   logic [3:0]  be;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic [31:0] d;
   logic [9:0]  dac;
   logic [2:0]  sel;
   int          mismatches;
   int          samples_checked;
   int          n;
   int          s;

   adcseq_top adcseq_top_inst (.core_clk_i(clk), .rstn_i(rstn), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wreq), .timer_module_trig_i(tmr), .external_trigger_pin_n_i(pin_n),
      .standby_i(stby), .module_stop_i(mstop), .cmp_hi_i(cmp), .dac_code_o(dac),
      .input_select_o(sel), .sample_o(smp), .conversion_done_interrupt_o(irq));
   adcseq_analog_model adcseq_analog_model_inst (.input_select_i(sel), .dac_code_i(dac), .cmp_hi_o(cmp));

   function automatic logic [9:0] lvl(input int i);
      return 10'h155 + 10'h044 * i;
   endfunction : lvl

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   // request held until waitrequest is sampled low at a rising edge, data taken at that edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v, input logic [3:0] b);
      int k;
      k = 0;
      @(posedge clk);
      rd   <= !w;
      wr   <= w;
      adr  <= a;
      wdat <= {24'h0, v};
      be   <= b;
      do begin
         @(posedge clk);
         k++;
      end while (wreq !== 1'b0 && k < 20);
      if (wreq !== 1'b0) begin
         mismatches++;
         wrap_up();
      end
      d  = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic t_reset;
      bus(0, 5'h00, 8'h00, 4'hF);
      check(d, 32'h0);
      bus(1, 5'h04, 8'h3F, 4'hF);
      bus(0, 5'h04, 8'h00, 4'hF);
      check(d, 32'h3F);
      bus(0, 5'h18, 8'h00, 4'hF);
      check(d, 32'h0);
      bus(1, 5'h00, 8'h27, 4'hF);
      repeat (5) @(posedge clk);
      bus(0, 5'h00, 8'h00, 4'hF);
      check(d, 32'h07);
   endtask : t_reset

   task automatic t_single;
      bus(1, 5'h00, 8'h69, 4'hF);
      bus(0, 5'h00, 8'h00, 4'hF);
      check(d[5], 1'b1);
      n = 0;
      s = 0;
      while (irq !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
         if (smp === 1'b1) begin
            s++;
         end
      end
      if (irq !== 1'b1) begin
         mismatches++;
         wrap_up();
      end
      check(n <= 134, 1'b1);
      check(s, 31);
      bus(0, 5'h00, 8'h00, 4'hF);
      check(d, 32'hC9);
      check(sel, 32'h1);
      bus(0, 5'h0C, 8'h00, 4'hF);
      check(d, {16'h0, lvl(1), 6'h00});
      bus(0, 5'h0C, 8'h00, 4'h2);
      check(d[15:8], lvl(1) >> 2);
      bus(0, 5'h0C, 8'h00, 4'h1);
      check(d[7:0], {lvl(1) & 10'h003, 6'h00});
      bus(1, 5'h00, 8'hC0, 4'hF);
      bus(0, 5'h00, 8'h00, 4'hF);
      check(d, 32'hC0);
      bus(1, 5'h00, 8'h40, 4'hF);
      bus(0, 5'h00, 8'h00, 4'hF);
      check(d, 32'h40);
      check(irq, 1'b0);
   endtask : t_single

   task automatic t_abort;
      bus(1, 5'h00, 8'h22, 4'hF);
      repeat (20) @(posedge clk);
      bus(1, 5'h00, 8'h00, 4'hF);
      repeat (300) @(posedge clk);
      bus(0, 5'h00, 8'h00, 4'hF);
      check(d, 32'h0);
      bus(1, 5'h00, 8'h22, 4'hF);
      repeat (265) @(posedge clk);
      bus(0, 5'h00, 8'h00, 4'hF);
      check(d, 32'h82);
      bus(0, 5'h10, 8'h00, 4'hF);
      check(d, {16'h0, lvl(2), 6'h00});
   endtask : t_abort

   task automatic t_trig;
      for (int c = 0; c < 4; c++) begin
         bus(1, 5'h04, 8'(c << 6), 4'hF);
         for (int p = 0; p < 2; p++) begin
            bus(1, 5'h00, 8'h08, 4'hF);
            @(posedge clk);
            tmr   <= (p == 0);
            pin_n <= (p == 0);
            @(posedge clk);
            tmr <= 1'b0;
            repeat (6) @(posedge clk);
            pin_n <= 1'b1;
            bus(0, 5'h00, 8'h00, 4'hF);
            check(d[5], c == 2 + p);
            mstop <= 1'b1;
            @(posedge clk);
            mstop <= 1'b0;
            bus(0, 5'h00, 8'h00, 4'hF);
            check(d[5], 1'b0);
         end
      end
      bus(1, 5'h04, 8'h00, 4'hF);
   endtask : t_trig

   task automatic t_scan;
      bus(1, 5'h00, 8'h3D, 4'hF);
      repeat (300) @(posedge clk);
      bus(0, 5'h00, 8'h00, 4'hF);
      check(d[7:5], 3'b101);
      bus(0, 5'h08, 8'h00, 4'hF);
      check(d, {16'h0, lvl(4), 6'h00});
      bus(0, 5'h0C, 8'h00, 4'hF);
      check(d, {16'h0, lvl(5), 6'h00});
      stby <= 1'b1;
      @(posedge clk);
      stby <= 1'b0;
      bus(0, 5'h00, 8'h00, 4'hF);
      check(d[5], 1'b0);
   endtask : t_scan

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      rstn            = 1'b0;
      rd              = 1'b0;
      wr              = 1'b0;
      adr             = 5'h00;
      wdat            = 32'h0;
      be              = 4'h0;
      tmr             = 1'b0;
      pin_n           = 1'b1;
      stby            = 1'b0;
      mstop           = 1'b0;
      mismatches      = 0;
      samples_checked = 0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_single();
      t_abort();
      t_trig();
      t_scan();
      wrap_up();
   end
endmodule : testbench
